// >>> src/acsc_pkg.sv
package acsc_pkg;

  // Register byte addresses on the APB port
  localparam logic [11:0] ADDR_CTRL0 = 12'h000;
  localparam logic [11:0] ADDR_RESULT = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;

  // Field positions of adc_control_zero and of the interrupt registers
  localparam int CTRL_PWR_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int CTRL_CHAN_LSB = 2;
  localparam int CTRL_CHAN_MSB = 5;
  localparam int CTRL_RSVD_LSB = 6;
  localparam int CTRL_RSVD_MSB = 7;
  localparam int IRQ_DONE_BIT = 0;

  // Channel codes
  localparam int NUM_INPUTS = 11;
  localparam logic [3:0] CHAN_LAST_INPUT = 4'hA;
  localparam logic [3:0] CHAN_FIXED_REF = 4'hF;

  // Values after reset
  localparam logic [3:0] CHAN_RESET = 4'h0;
  localparam logic PWR_RESET = 1'b0;
  localparam logic DONE_FLAG_RESET = 1'b0;
  localparam logic IRQ_EN_RESET = 1'b0;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [10:0] ANALOG_SEL_RESET = 11'h000;

  // Conversion timing: one bit period, ten periods per conversion
  localparam int CLK_PERIOD_NS = 50;
  localparam int TAD_NS = 1600;
  localparam int TAD_CYCLES = (TAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] TAD_LAST = 6'(TAD_CYCLES - 1);
  localparam int TAD_PER_CONV = 10;
  localparam int CONV_CYCLES = TAD_PER_CONV * TAD_CYCLES;
  localparam logic [2:0] SAR_MSB = 3'h7;
  localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;

  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_HOLD,
    SAR_BITS,
    SAR_FINISH
  } acsc_sar_state_t;

endpackage

// >>> src/acsc_sar.sv
`timescale 1ns/1ps
module acsc_sar
  import acsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tad_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic comp_i,
  output logic busy_o,
  output logic done_o,
  output logic load_o,
  output logic [7:0] result_o,
  output logic [7:0] dac_o
);

  acsc_sar_state_t state_q;
  logic [2:0] bit_q;
  logic [7:0] code_q;
  logic [7:0] fill;
  logic last_bit;

  // Partial result: bits not yet decided copy the last decided bit
  always_comb begin
    fill = code_q;
    last_bit = 1'b0;
    if (state_q == SAR_BITS && bit_q != SAR_MSB) begin
      last_bit = code_q[3'(bit_q + 3'h1)];
    end
    for (int j = 0; j < 8; j++) begin
      if (state_q == SAR_HOLD || (state_q == SAR_BITS && j <= int'(bit_q))) begin
        fill[j] = last_bit;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= SAR_IDLE;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      load_o <= 1'b0;
      bit_q <= SAR_MSB;
      code_q <= RESULT_RESET;
      result_o <= RESULT_RESET;
    end else begin
      done_o <= 1'b0;
      load_o <= 1'b0;
      if (abort_i && busy_o) begin
        state_q <= SAR_IDLE;
        busy_o <= 1'b0;
        load_o <= 1'b1;
        result_o <= fill;
        code_q <= RESULT_RESET;
      end else if (start_i && !busy_o) begin
        state_q <= SAR_HOLD;
        busy_o <= 1'b1;
        bit_q <= SAR_MSB;
        code_q <= RESULT_RESET;
      end else if (tad_i) begin
        case (state_q)
          SAR_HOLD: begin
            state_q <= SAR_BITS;
            code_q <= SAR_FIRST_TRIAL;
          end
          SAR_BITS: begin
            code_q[bit_q] <= comp_i;
            if (bit_q != 3'h0) begin
              code_q[3'(bit_q - 3'h1)] <= 1'b1;
              bit_q <= 3'(bit_q - 3'h1);
            end else begin
              state_q <= SAR_FINISH;
            end
          end
          SAR_FINISH: begin
            state_q <= SAR_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            load_o <= 1'b1;
            result_o <= code_q;
          end
          default: begin
            state_q <= SAR_IDLE;
          end
        endcase
      end
    end
  end

  assign dac_o = code_q;

endmodule

// >>> src/acsc_top.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Channel field bits 5..2 codes 0..10 route inputs zero to ten; 11..14 reserved.
// - Channel code 15 connects the fixed reference to the sampler.
// - Writing one to go bit 1 starts conversion; reads one while running.
// - Hardware clears the go bit itself when the conversion ends.
// - Go bit reading zero means no conversion is running.
// - Power bit 0 set enables the converter.
// - Power bit clear disables the converter with no operating current.
// - Control bits 7 and 6 ignore writes and read zero.
// - Completion clears go, sets done flag and loads the result.
// - Clearing go early stops and stores partial result, filled with last bit.
// - Done flag sets on every completion, whatever the interrupt enable.
module acsc_top
  import acsc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic IRQ_O,
  input wire logic COMP_I,
  output logic CONV_POWER_O,
  output logic [10:0] ANALOG_SEL_O,
  output logic FIXED_REF_SEL_O,
  output logic SAMPLE_HOLD_O,
  output logic [7:0] DAC_CODE_O
);

  logic [3:0] chan_q;
  logic pwr_q;
  logic done_flag_q;
  logic irq_en_q;
  logic comp_s1_q;
  logic comp_s2_q;
  logic [5:0] tad_cnt_q;
  logic [15:0] conv_len_q;
  logic access;
  logic commit;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic mapped;
  logic [31:0] rd_mux;
  logic go_new;
  logic pwr_new;
  logic sar_start;
  logic sar_abort;
  logic sar_tad;
  logic sar_busy;
  logic sar_done;
  logic sar_load;
  logic [7:0] sar_result;

  // APB: one wait state, so every transfer has two access cycles
  assign access = PSEL_I & PENABLE_I;
  assign commit = access & PREADY_O;
  assign mapped = (PADDR_I == ADDR_CTRL0) || (PADDR_I == ADDR_RESULT) ||
                  (PADDR_I == ADDR_IRQ_STATUS) || (PADDR_I == ADDR_IRQ_MASK);
  assign wr_ctrl = commit & PWRITE_I & (PADDR_I == ADDR_CTRL0);
  assign wr_status = commit & PWRITE_I & (PADDR_I == ADDR_IRQ_STATUS);
  assign wr_mask = commit & PWRITE_I & (PADDR_I == ADDR_IRQ_MASK);
  assign go_new = PWDATA_I[CTRL_GO_BIT];
  assign pwr_new = PWDATA_I[CTRL_PWR_BIT];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR_I)
      ADDR_CTRL0: begin
        rd_mux[CTRL_CHAN_MSB:CTRL_CHAN_LSB] = chan_q;
        rd_mux[CTRL_GO_BIT] = sar_busy;
        rd_mux[CTRL_PWR_BIT] = pwr_q;
        rd_mux[CTRL_RSVD_MSB:CTRL_RSVD_LSB] = 2'h0;
      end
      ADDR_RESULT: begin
        rd_mux[7:0] = sar_result;
      end
      ADDR_IRQ_STATUS: begin
        rd_mux[IRQ_DONE_BIT] = done_flag_q;
      end
      ADDR_IRQ_MASK: begin
        rd_mux[IRQ_DONE_BIT] = irq_en_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else if (access && !PREADY_O) begin
      PREADY_O <= 1'b1;
      PSLVERR_O <= !mapped;
      PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_mux;
    end else begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end
  end

  // Start needs power already on before this write, so a write that
  // powers up and sets go together leaves the converter idle
  assign sar_start = wr_ctrl & go_new & pwr_new & pwr_q & !sar_busy;
  assign sar_abort = wr_ctrl & sar_busy & (!go_new | !pwr_new);

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      chan_q <= CHAN_RESET;
      pwr_q <= PWR_RESET;
    end else if (wr_ctrl) begin
      chan_q <= PWDATA_I[CTRL_CHAN_MSB:CTRL_CHAN_LSB];
      pwr_q <= pwr_new;
    end
  end

  // Analog routing; everything is released while unpowered
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ANALOG_SEL_O <= ANALOG_SEL_RESET;
      FIXED_REF_SEL_O <= 1'b0;
      CONV_POWER_O <= 1'b0;
    end else begin
      CONV_POWER_O <= pwr_q;
      ANALOG_SEL_O <= ANALOG_SEL_RESET;
      FIXED_REF_SEL_O <= 1'b0;
      if (pwr_q && chan_q <= CHAN_LAST_INPUT) begin
        ANALOG_SEL_O[chan_q] <= 1'b1;
      end
      if (pwr_q && chan_q == CHAN_FIXED_REF) begin
        FIXED_REF_SEL_O <= 1'b1;
      end
    end
  end

  // Comparator is asynchronous to the system clock
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
    end else begin
      comp_s1_q <= COMP_I;
      comp_s2_q <= comp_s1_q;
    end
  end

  // Bit period divider; runs only during a conversion to save power
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tad_cnt_q <= 6'h00;
    end else if (!sar_busy || sar_tad) begin
      tad_cnt_q <= 6'h00;
    end else begin
      tad_cnt_q <= 6'(tad_cnt_q + 6'h01);
    end
  end

  assign sar_tad = sar_busy & (tad_cnt_q == TAD_LAST);

  acsc_sar u_sar (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .tad_i(sar_tad),
    .start_i(sar_start),
    .abort_i(sar_abort),
    .comp_i(comp_s2_q),
    .busy_o(sar_busy),
    .done_o(sar_done),
    .load_o(sar_load),
    .result_o(sar_result),
    .dac_o(DAC_CODE_O)
  );

  assign SAMPLE_HOLD_O = sar_busy;

  // Done flag: write one to clear; a completion in the same cycle wins
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      done_flag_q <= DONE_FLAG_RESET;
    end else if (sar_done) begin
      done_flag_q <= 1'b1;
    end else if (wr_status && PWDATA_I[IRQ_DONE_BIT]) begin
      done_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      irq_en_q <= IRQ_EN_RESET;
    end else if (wr_mask) begin
      irq_en_q <= PWDATA_I[IRQ_DONE_BIT];
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= done_flag_q & irq_en_q;
    end
  end

  // Helper: length of the running conversion, read only by checks
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      conv_len_q <= 16'h0000;
    end else if (sar_start) begin
      conv_len_q <= 16'h0000;
    end else if (sar_busy) begin
      conv_len_q <= 16'(conv_len_q + 16'h0001);
    end
  end

  sequence seq_finish;
    sar_done ##0 !sar_busy;
  endsequence

  sequence seq_abort;
    sar_abort ##1 (sar_load && !sar_done && !sar_busy);
  endsequence

  AST_CHAN_ROUTE: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (pwr_q && chan_q <= CHAN_LAST_INPUT && !wr_ctrl) |=>
      (ANALOG_SEL_O == (11'h001 << $past(chan_q)) && !FIXED_REF_SEL_O))
    else $error("selected input not routed");

  AST_FIXED_REF: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (pwr_q && chan_q == CHAN_FIXED_REF) |=> (FIXED_REF_SEL_O && ANALOG_SEL_O == 11'h000))
    else $error("fixed reference not routed");

  AST_GO_START: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    // Three cycles: the fastest back-to-back abort lands on the fourth
    sar_start |=> (sar_busy && SAMPLE_HOLD_O)[*3])
    else $error("conversion did not start");

  AST_GO_SELF_CLEAR: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    seq_finish |-> ($past(sar_busy) && conv_len_q == 16'(CONV_CYCLES)))
    else $error("go bit not cleared at end of conversion");

  AST_GO_READ: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (commit && !PWRITE_I && PADDR_I == ADDR_CTRL0) |->
      (PRDATA_O[CTRL_GO_BIT] == $past(sar_busy)))
    else $error("go bit read does not match conversion state");

  AST_POWER_ON: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    pwr_q |=> CONV_POWER_O)
    else $error("converter not powered");

  AST_POWER_OFF: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    !pwr_q |=> (!CONV_POWER_O && ANALOG_SEL_O == 11'h000 && !FIXED_REF_SEL_O && !sar_busy))
    else $error("converter active while unpowered");

  AST_RSVD_ZERO: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (commit && !PWRITE_I && PADDR_I == ADDR_CTRL0) |->
      (PRDATA_O[CTRL_RSVD_MSB:CTRL_RSVD_LSB] == 2'h0))
    else $error("reserved control bits not zero");

  AST_DONE_UPDATE: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    seq_finish |=> (done_flag_q && !sar_busy && sar_result == $past(sar_result)))
    else $error("completion did not set flag and keep result");

  AST_ABORT_PARTIAL: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    seq_abort |=> (done_flag_q == $past(done_flag_q) || $past(wr_status)))
    else $error("abort raised the done flag");

  AST_FLAG_ALWAYS: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (sar_done && !irq_en_q) |=> done_flag_q ##1 (!IRQ_O || irq_en_q))
    else $error("done flag missed while interrupt disabled");

  AST_CHAN_RESERVED: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (chan_q > CHAN_LAST_INPUT && chan_q != CHAN_FIXED_REF) |=> (ANALOG_SEL_O == 11'h000 && !FIXED_REF_SEL_O))
    else $error("reserved channel routed an input");

  AST_SEL_ONE_HOT: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    $onehot0(ANALOG_SEL_O) && !(FIXED_REF_SEL_O && ANALOG_SEL_O != 11'h000))
    else $error("more than one source routed");

  AST_NO_START_UNPOWERED: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (wr_ctrl && go_new && !pwr_q) |=> !sar_busy)
    else $error("conversion started before power was on");

  AST_BUSY_POWERED: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    sar_busy |-> pwr_q)
    else $error("conversion running while unpowered");

  AST_TAD_RANGE: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    tad_cnt_q <= TAD_LAST)
    else $error("bit period counter out of range");

  AST_RESULT_AT_LOAD: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    $changed(sar_result) |-> sar_load)
    else $error("result changed without a completion or abort");

  AST_FLAG_FROM_DONE: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    $rose(done_flag_q) |-> $past(sar_done))
    else $error("done flag set without a completion");

  AST_FLAG_STICKY: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (done_flag_q && !(wr_status && PWDATA_I[IRQ_DONE_BIT])) |=> done_flag_q)
    else $error("done flag cleared without a write of one");

  AST_IRQ_LEVEL: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    IRQ_O == $past(done_flag_q && irq_en_q))
    else $error("interrupt level does not follow flag and enable");

endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import acsc_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic comp = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, conv_pwr, fref, shold;
  logic [10:0] asel;
  logic [7:0] dac;
  logic [7:0] target = 8'h00;
  logic [31:0] lfsr_q = 32'hC71790B2;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int samples_checked = 0;

  acsc_top acsc_top_i (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .IRQ_O(irq), .COMP_I(comp), .CONV_POWER_O(conv_pwr), .ANALOG_SEL_O(asel),
    .FIXED_REF_SEL_O(fref), .SAMPLE_HOLD_O(shold), .DAC_CODE_O(dac));

  always #25 clk = ~clk;

  // Comparator model: analog level held in target, high while input >= trial code
  always @(posedge clk) begin
    comp <= (target >= dac);
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [10:0] exp_sel(input logic [3:0] ch, input logic on);
    return (on && ch <= CHAN_LAST_INPUT) ? (11'h001 << ch) : 11'h000;
  endfunction

  // Abort after two decided bits: the lower bits copy the second one
  function automatic logic [7:0] exp_part(input logic [7:0] t);
    return {t[7], {7{t[6]}}};
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; waits for ready under a bound, never assuming the wait length
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      $display("mismatch pready expected 1 seen timeout");
      summarize();
    end
  endtask

  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  // Power the converter up, then start a conversion and poll the go bit
  task automatic convert(input logic [3:0] ch, input logic [7:0] t);
    int n;
    target <= t;
    apb(1'b1, ADDR_CTRL0, {26'h0, ch, 2'b01});
    repeat (8) @(posedge clk);
    apb(1'b1, ADDR_CTRL0, {26'h0, ch, 2'b11});
    rdchk("go_running", ADDR_CTRL0, {26'h0, ch, 2'b11});
    chk("hold_out", 32'h1, {31'h0, shold});
    n = 0;
    do begin
      apb(1'b0, ADDR_CTRL0, 32'h0);
      n++;
    end while (rd[CTRL_GO_BIT] !== 1'b0 && n < 400);
    chk("go_cleared", {26'h0, ch, 2'b01}, rd);
    if (rd[CTRL_GO_BIT] !== 1'b0) summarize();
    rdchk("result", ADDR_RESULT, {24'h0, t});
    rdchk("done_flag", ADDR_IRQ_STATUS, 32'h1);
  endtask

  initial begin
    logic [3:0] ch;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rdchk("ctrl_reset", ADDR_CTRL0, 32'h0);
    rdchk("result_reset", ADDR_RESULT, 32'h0);
    rdchk("status_reset", ADDR_IRQ_STATUS, 32'h0);
    rdchk("mask_reset", ADDR_IRQ_MASK, 32'h0);
    chk("outs_reset", 32'h0, {conv_pwr, fref, shold, irq, asel, dac});
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b1, 12'hFFC, 32'hFFFF_FFFF);
    chk("unmapped_werr", 32'h1, {31'h0, err});
    // Reserved bits written high must never read back
    apb(1'b1, ADDR_CTRL0, 32'h0000_00C0);
    rdchk("rsvd_bits", ADDR_CTRL0, 32'h0);
    chk("power_off", 32'h0, {19'h0, conv_pwr, fref, asel});
    // Every channel code, unpowered then powered
    for (int c = 0; c < 16; c++) begin
      ch = c[3:0];
      apb(1'b1, ADDR_CTRL0, {26'h0, ch, 2'b00});
      repeat (2) @(posedge clk);
      chk("sel_off", 32'h0, {19'h0, conv_pwr, fref, asel});
      apb(1'b1, ADDR_CTRL0, {26'h0, ch, 2'b01});
      repeat (2) @(posedge clk);
      chk("pwr_on", 32'h1, {31'h0, conv_pwr});
      chk("sel_on", {21'h0, exp_sel(ch, 1'b1)}, {21'h0, asel});
      chk("fref", {31'h0, ch == CHAN_FIXED_REF}, {31'h0, fref});
    end
    // Power and go in one write: go must be ignored
    apb(1'b1, ADDR_CTRL0, 32'h0);
    apb(1'b1, ADDR_CTRL0, 32'h0000_0003);
    rdchk("go_same_write", ADDR_CTRL0, 32'h1);
    rdchk("idle_go", ADDR_CTRL0, 32'h1);
    // Polled conversion, interrupt masked
    lfsr_q = lfsr(lfsr_q);
    convert(lfsr_q[3:0] % 4'hB, lfsr_q[15:8]);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    rdchk("w1c", ADDR_IRQ_STATUS, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_off", 32'h0, {31'h0, irq});
    // Corner channels, the first two with corner targets, interrupt enabled
    convert(4'hF, 8'hFF);
    chk("irq_done", 32'h1, {31'h0, irq});
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    convert(4'h0, 8'h00);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    lfsr_q = lfsr(lfsr_q);
    convert(4'hA, lfsr_q[7:0]);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    // Abort inside the hold period: no bit decided yet
    apb(1'b1, ADDR_CTRL0, 32'h0000_0007);
    apb(1'b1, ADDR_CTRL0, 32'h0000_0005);
    rdchk("abort_go", ADDR_CTRL0, 32'h5);
    rdchk("abort_result", ADDR_RESULT, 32'h0);
    rdchk("abort_noflag", ADDR_IRQ_STATUS, 32'h0);
    // Abort about 104 cycles in: bits 7 and 6 decided, well clear of the next decision
    lfsr_q = lfsr(lfsr_q);
    target <= lfsr_q[7:0];
    apb(1'b1, ADDR_CTRL0, 32'h0000_000F);
    repeat (100) @(posedge clk);
    apb(1'b1, ADDR_CTRL0, 32'h0000_000D);
    rdchk("abort_fill", ADDR_RESULT, {24'h0, exp_part(lfsr_q[7:0])});
    rdchk("abort_fill_noflag", ADDR_IRQ_STATUS, 32'h0);
    summarize();
  end
endmodule
